// [core_model.sv]
// core-side partner: answers vector fetches and stacking requests
// assumes the block holds fetch and stack levels until answered
`timescale 1ns/100ps
module core_model #(
  parameter logic [31:0] SP_WORD = 32'h2000_0ff0
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire intc_pkg::fetch_t i_fetch,
  input wire intc_pkg::stack_t i_stack,
  input wire logic [3:0] i_wait,
  output logic o_ack,
  output logic [31:0] o_data,
  output logic o_done
);
  logic ack_ff;
  logic done_ff;
  logic [3:0] fetch_cnt_ff;
  logic [3:0] stack_cnt_ff;
  logic [31:0] word_ff;

  // =====================================================
  // vector table
  // stack word first, handlers odd
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_ff <= 1'b0;
      fetch_cnt_ff <= 4'h0;
      word_ff <= 32'h0;
    end else if (ack_ff || !i_fetch.req) begin
      ack_ff <= 1'b0;
      fetch_cnt_ff <= 4'h0;
    end else if (fetch_cnt_ff >= i_wait) begin
      ack_ff <= 1'b1;
      word_ff <= (i_fetch.addr == intc_pkg::OFS_SP) ? SP_WORD :
        {18'h0, i_fetch.addr, 4'h1};
    end else begin
      fetch_cnt_ff <= fetch_cnt_ff + 4'h1;
    end
  end
  // released bus shows the inverse so stale data cannot pass
  assign o_data = ack_ff ? word_ff : ~word_ff;
  assign o_ack = ack_ff;

  // =====================================================
  // stacking
  // state saved and restored here
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      done_ff <= 1'b0;
      stack_cnt_ff <= 4'h0;
    end else if (done_ff || !(i_stack.push || i_stack.pop)) begin
      done_ff <= 1'b0;
      stack_cnt_ff <= 4'h0;
    end else if (stack_cnt_ff >= i_wait) begin
      done_ff <= 1'b1;
    end else begin
      stack_cnt_ff <= stack_cnt_ff + 4'h1;
    end
  end
  assign o_done = done_ff;
endmodule // core_model

// [intc_pkg.sv]
// constants, types and carriers for the vectored interrupt routing block
// assumes one system clock; the core fetches vectors and stacks state
//
// Operation
// - 16 system slots, 32 peripheral lines
// - offset 0x00 stack pointer, 0x04 reset
// - reset, nmi, hard fault fixed; escalation
// - memory, bus, usage faults programmable priority
// - call, monitor, pended, tick programmable; gaps reserved
// - peripheral n is exception n plus 16
// - nmi selectable from any pin or none
// - implemented priority bits three to eight
// - live priorities; grouping splits preempt and sub
// - tail-chaining and late arrival supported
// - state stacked on entry, restored on exit
// - equal priority: lower vector number first
// - each vector picks one of three sources
// - both dma terminal outputs directly selectable
// - array lines usable as any interrupt; array line n feeds only vector n here
// - fixed sources and alternatives per vector
package intc_pkg;
  localparam int N_IRQ = 32;
  localparam int N_EXC = 48;
  localparam int IRQ_BASE = 16;
  localparam int DMA_HALF = 16;
  localparam int N_FAULT = 3;
  localparam int N_SYS = 7;
  localparam int PIN_N = 8;
  localparam int ADDR_W = 10;
  localparam int NUM_W = 6;
  localparam int KEY_W = 9;
  typedef logic [ADDR_W-1:0] vec_addr_t;
  typedef logic [NUM_W-1:0] exc_num_t;
  typedef logic [KEY_W-1:0] key_t;
  // vector table offsets; irq n sits at OFS_IRQ0 plus four n
  localparam vec_addr_t OFS_SP = 10'h000;
  localparam vec_addr_t OFS_RESET = 10'h004;
  localparam vec_addr_t OFS_IRQ0 = 10'h040;
  localparam vec_addr_t OFS_TABLE_END = 10'h3fc;
  localparam logic [1:0] VEC_PAD = 2'h0;
  localparam logic [31:0] THUMB_BIT = 32'h0000_0001;
  localparam exc_num_t EXC_RESET = 6'h01;
  localparam exc_num_t EXC_NMI = 6'h02;
  localparam exc_num_t EXC_HARD = 6'h03;
  localparam exc_num_t EXC_MEM = 6'h04;
  localparam exc_num_t EXC_BUS = 6'h05;
  localparam exc_num_t EXC_USAGE = 6'h06;
  localparam exc_num_t EXC_SVC = 6'h0b;
  localparam exc_num_t EXC_DBG = 6'h0c;
  localparam exc_num_t EXC_PENDED_SERVICE_REQUEST = 6'h0e;
  localparam exc_num_t EXC_TICK = 6'h0f;
  // slot 0 and slots 7..10, 13 never pend
  localparam logic [N_EXC-1:0] RESV_EXC_MASK = 48'h0000_0000_2781;
  // vectors 2, 14, 26..28 have no fixed-function source
  localparam logic [N_IRQ-1:0] RESV_FIXED_MASK = 32'h1c00_4004;
  localparam int SYS_MEM = 0;
  localparam int SYS_BUS = 1;
  localparam int SYS_USAGE = 2;
  localparam int SYS_SVC = 3;
  localparam int SYS_DBG = 4;
  localparam int SYS_PENDED_SERVICE_REQUEST = 5;
  localparam int SYS_TICK = 6;
  // smaller key wins; fixed -3, -2, -1 map onto 0, 1, 2
  localparam key_t KEY_RESET = 9'h000;
  localparam key_t KEY_NMI = 9'h001;
  localparam key_t KEY_HARD = 9'h002;
  localparam key_t KEY_PROG_BASE = 9'h003;
  localparam key_t KEY_IDLE = 9'h1ff;
  localparam logic [3:0] PRIO_BITS_MIN = 4'h3;
  localparam logic [3:0] PRIO_BITS_MAX = 4'h8;
  localparam logic [7:0] PRIO_ALL = 8'hff;
  localparam logic [7:0] GROUP_BASE = 8'hfe;
  localparam logic [1:0] SRC_FIXED = 2'h0;
  localparam logic [1:0] SRC_DMA = 2'h1;
  localparam logic [1:0] SRC_ARRAY = 2'h2;
  typedef enum {
    ST_FETCH_SP, ST_FETCH_RST, ST_RUN, ST_STACK, ST_FETCH_VEC, ST_UNSTACK
  } state_t;
  typedef struct packed {
    logic req;
    vec_addr_t addr;
  } fetch_t;
  typedef struct packed {
    logic push;
    logic pop;
  } stack_t;
  typedef struct packed {
    logic valid;
    exc_num_t num;
    logic [31:0] handler;
    logic tail_chain;
  } entry_t;
endpackage

// [routing_checker_sva.sv]
// port checker for the vectored interrupt routing block
// assumes one clock domain and the active-low asynchronous reset
`timescale 1ns/100ps
module routing_checker (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_fetch_ack,
  input wire logic [31:0] i_fetch_data,
  input wire logic i_stack_done,
  input wire intc_pkg::fetch_t o_fetch,
  input wire intc_pkg::stack_t o_stack,
  input wire intc_pkg::entry_t o_entry,
  input wire logic o_sp_valid,
  input wire logic [31:0] o_main_stack_pointer
);
  wire logic taken = o_fetch.req && i_fetch_ack;
  wire logic sp_take = taken && (o_fetch.addr == intc_pkg::OFS_SP);

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  // =====================================================
  // vector fetch
  a_req_holds: assert property (
    o_fetch.req && !i_fetch_ack |=> o_fetch.req && $stable(o_fetch.addr))
    else $error("fetch request dropped or moved before ack");
  a_sp_capture: assert property (
    sp_take |=> o_sp_valid && o_main_stack_pointer == $past(i_fetch_data))
    else $error("stack pointer word not captured");
  a_reset_next: assert property (
    sp_take |=> o_fetch.req && o_fetch.addr == intc_pkg::OFS_RESET)
    else $error("reset vector not fetched after stack word");
  a_entry_vector: assert property (
    taken && !sp_take |=> o_entry.valid
      && o_entry.handler == ($past(i_fetch_data) & ~intc_pkg::THUMB_BIT)
      && {2'h0, o_entry.num, 2'h0} == $past(o_fetch.addr))
    else $error("entry does not match fetched vector");
  a_sp_pulse: assert property (
    o_sp_valid |=> !o_sp_valid)
    else $error("stack pointer valid longer than one cycle");
  a_entry_legal: assert property (
    o_entry.valid |-> !intc_pkg::RESV_EXC_MASK[o_entry.num])
    else $error("entry to a reserved slot");

  // =====================================================
  // stacking
  a_push_holds: assert property (
    o_stack.push && !i_stack_done |=> o_stack.push)
    else $error("push released before done");
  a_push_fetch: assert property (
    o_stack.push && i_stack_done |=> !o_stack.push && o_fetch.req
      && o_fetch.addr[1:0] == 2'h0
      && o_fetch.addr inside {[10'h008:10'h0bc]})
    else $error("no vector fetch after stacking");
  a_pop_holds: assert property (
    o_stack.pop && !i_stack_done |=> o_stack.pop)
    else $error("pop released before done");
  a_one_stack_op: assert property (
    !(o_stack.push && o_stack.pop))
    else $error("push and pop together");
endmodule // routing_checker

bind vectored_interrupt_routing routing_checker chk (.i_mclk, .i_rst_b,
  .i_fetch_ack, .i_fetch_data, .i_stack_done, .o_fetch, .o_stack,
  .o_entry, .o_sp_valid, .o_main_stack_pointer);

// [vectored_interrupt_routing.sv]
// nested vector controller with per-vector source selection
// assumes the core answers vector fetches and stacking on this clock;
// pins for the nmi come from outside and are synchronised here
`timescale 1ns/100ps
module vectored_interrupt_routing (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [31:0] i_fixed_src,
  input wire logic [15:0] i_dma_terminal_out_low,
  input wire logic [15:0] i_dma_terminal_out_high,
  input wire logic [31:0] i_array_line,
  input wire logic [31:0][1:0] i_src_sel,
  input wire logic [31:0] i_irq_en,
  input wire logic [31:0][7:0] i_irq_prio,
  input wire logic [6:0][7:0] i_sys_prio,
  input wire logic [2:0] i_fault_en,
  input wire logic [3:0] i_prio_bits,
  input wire logic [2:0] i_prio_group,
  input wire logic i_primask,
  input wire logic [2:0] i_fault_req,
  input wire logic i_bus_err,
  input wire logic i_svc_req,
  input wire logic i_dbg_req,
  input wire logic i_pended_service_request_req,
  input wire logic i_tick_req,
  input wire logic [7:0] i_pins,
  input wire logic i_nmi_en,
  input wire logic [2:0] i_nmi_pin,
  input wire logic i_fetch_ack,
  input wire logic [31:0] i_fetch_data,
  input wire logic i_stack_done,
  input wire logic i_exc_return,
  output intc_pkg::fetch_t o_fetch,
  output intc_pkg::stack_t o_stack,
  output intc_pkg::entry_t o_entry,
  output logic o_sp_valid,
  output logic [31:0] o_main_stack_pointer
);

  intc_pkg::state_t state_ff;
  intc_pkg::fetch_t fetch_ff;
  intc_pkg::stack_t stack_ff;
  intc_pkg::entry_t entry_ff;
  logic sp_valid_ff;
  logic [31:0] msp_ff;
  intc_pkg::exc_num_t target_ff;
  logic chain_ff;
  logic thumb_err_ff;
  logic [47:0] pend_ff;
  logic [47:0] active_ff;
  logic [47:0] set_c;
  logic [47:0] clr_c;
  logic [47:0] en_c;
  logic [47:0] elig_c;
  logic [47:0] act_after_c;
  logic [47:0][8:0] kfull_c;
  logic [47:0][8:0] kpre_c;
  logic [7:0] impl_mask_c;
  logic [7:0] grp_mask_c;
  logic [31:0] vec_req_c;
  logic [6:0] win_c;
  logic [6:0] cur_c;
  logic [6:0] aft_c;
  intc_pkg::key_t run_key_c;
  intc_pkg::key_t aft_key_c;
  logic take_c;
  logic chain_c;
  logic late_c;
  logic ret_c;
  logic entry_c;
  intc_pkg::exc_num_t tgt_c;
  logic [7:0] pin_s1_ff;
  logic [7:0] pin_s2_ff;
  logic [7:0] pin_s3_ff;
  logic [7:0] pin_stable_ff;
  logic nmi_lvl_ff;
  logic nmi_lvl_c;

  // =========================================================
  // arbitration helper
  // strict compare in ascending order keeps the lower number
  // tie to lower number
  function automatic logic [6:0] pick(
    input logic [47:0] m,
    input logic [47:0][8:0] k
  );
    logic [6:0] r;
    intc_pkg::key_t best;
    r = '0;
    best = intc_pkg::KEY_IDLE;
    for (int i = 0; i < intc_pkg::N_EXC; i++) begin
      if (m[i] && (!r[intc_pkg::NUM_W] || k[i] < best)) begin
        r = {1'b1, intc_pkg::exc_num_t'(i)};
        best = k[i];
      end
    end
    return r;
  endfunction

  // =========================================================
  // priority keys
  // implemented bits clamp
  always_comb begin
    logic [3:0] nb;
    nb = i_prio_bits;
    if (nb < intc_pkg::PRIO_BITS_MIN) begin
      nb = intc_pkg::PRIO_BITS_MIN;
    end
    if (nb > intc_pkg::PRIO_BITS_MAX) begin
      nb = intc_pkg::PRIO_BITS_MAX;
    end
    impl_mask_c = ~(intc_pkg::PRIO_ALL >> nb);
    grp_mask_c = intc_pkg::GROUP_BASE << i_prio_group;
  end

  // keys follow the priority inputs live, so reprioritising
  // takes effect on the next arbitration
  always_comb begin
    logic [7:0] p;
    logic prog;
    intc_pkg::key_t fk;
    p = '0;
    prog = 1'b1;
    fk = intc_pkg::KEY_IDLE;
    for (int i = 0; i < intc_pkg::N_EXC; i++) begin
      p = '0;
      prog = 1'b1;
      fk = intc_pkg::KEY_IDLE;
      case (intc_pkg::exc_num_t'(i))
        intc_pkg::EXC_RESET: begin
          prog = 1'b0;
          fk = intc_pkg::KEY_RESET;
        end
        intc_pkg::EXC_NMI: begin
          prog = 1'b0;
          fk = intc_pkg::KEY_NMI;
        end
        intc_pkg::EXC_HARD: begin
          prog = 1'b0;
          fk = intc_pkg::KEY_HARD;
        end
        intc_pkg::EXC_MEM: p = i_sys_prio[intc_pkg::SYS_MEM];
        intc_pkg::EXC_BUS: p = i_sys_prio[intc_pkg::SYS_BUS];
        intc_pkg::EXC_USAGE: p = i_sys_prio[intc_pkg::SYS_USAGE];
        intc_pkg::EXC_SVC: p = i_sys_prio[intc_pkg::SYS_SVC];
        intc_pkg::EXC_DBG: p = i_sys_prio[intc_pkg::SYS_DBG];
        intc_pkg::EXC_PENDED_SERVICE_REQUEST: p = i_sys_prio[intc_pkg::SYS_PENDED_SERVICE_REQUEST];
        intc_pkg::EXC_TICK: p = i_sys_prio[intc_pkg::SYS_TICK];
        default: begin
          if (i >= intc_pkg::IRQ_BASE) begin
            p = i_irq_prio[i - intc_pkg::IRQ_BASE];
          end else begin
            prog = 1'b0;
          end
        end
      endcase
      kfull_c[i] = prog ?
        intc_pkg::KEY_PROG_BASE + {1'b0, p & impl_mask_c} : fk;
      kpre_c[i] = prog ?
        intc_pkg::KEY_PROG_BASE + {1'b0, p & impl_mask_c & grp_mask_c} : fk;
    end
  end

  // =========================================================
  // source selection
  // three-way mux
  always_comb begin
    logic d;
    d = 1'b0;
    for (int n = 0; n < intc_pkg::N_IRQ; n++) begin
      d = (n < intc_pkg::DMA_HALF) ?
        i_dma_terminal_out_low[n % intc_pkg::DMA_HALF] :
        i_dma_terminal_out_high[n % intc_pkg::DMA_HALF];
      case (i_src_sel[n])
        intc_pkg::SRC_DMA: vec_req_c[n] = d;
        intc_pkg::SRC_ARRAY: vec_req_c[n] = i_array_line[n];
        default: vec_req_c[n] =
          i_fixed_src[n] & ~intc_pkg::RESV_FIXED_MASK[n];
      endcase
    end
  end

  // =========================================================
  // nmi pin selection
  // three stages; second and third must agree before a change counts
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
      pin_stable_ff <= '0;
    end else begin
      pin_s1_ff <= i_pins;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      for (int j = 0; j < intc_pkg::PIN_N; j++) begin
        if (pin_s2_ff[j] == pin_s3_ff[j]) begin
          pin_stable_ff[j] <= pin_s3_ff[j];
        end
      end
    end
  end

  assign nmi_lvl_c = i_nmi_en & pin_stable_ff[i_nmi_pin];

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      nmi_lvl_ff <= 1'b0;
    end else begin
      nmi_lvl_ff <= nmi_lvl_c;
    end
  end

  // =========================================================
  // arbitration
  always_comb begin
    en_c = '1;
    en_c[intc_pkg::IRQ_BASE +: intc_pkg::N_IRQ] = i_irq_en;
    for (int f = 0; f < intc_pkg::N_FAULT; f++) begin
      en_c[intc_pkg::EXC_MEM + f] = i_fault_en[f];
    end
    for (int i = 0; i < intc_pkg::N_EXC; i++) begin
      elig_c[i] = pend_ff[i] & en_c[i] & ~active_ff[i] &
        ~(i_primask && kfull_c[i] >= intc_pkg::KEY_PROG_BASE);
    end
  end

  assign win_c = pick(elig_c, kfull_c);
  assign cur_c = pick(active_ff, kfull_c);
  assign run_key_c = cur_c[intc_pkg::NUM_W] ?
    kpre_c[cur_c[5:0]] : intc_pkg::KEY_IDLE;

  always_comb begin
    act_after_c = active_ff;
    if (cur_c[intc_pkg::NUM_W]) begin
      act_after_c[cur_c[5:0]] = 1'b0;
    end
  end

  assign aft_c = pick(act_after_c, kfull_c);
  assign aft_key_c = aft_c[intc_pkg::NUM_W] ?
    kpre_c[aft_c[5:0]] : intc_pkg::KEY_IDLE;
  assign take_c = win_c[intc_pkg::NUM_W] && kpre_c[win_c[5:0]] < run_key_c;
  assign chain_c = win_c[intc_pkg::NUM_W] &&
    kpre_c[win_c[5:0]] < aft_key_c;
  assign late_c = take_c && kpre_c[win_c[5:0]] < kpre_c[target_ff];
  assign tgt_c = late_c ? win_c[5:0] : target_ff;
  assign ret_c = (state_ff == intc_pkg::ST_RUN) && i_exc_return &&
    cur_c[intc_pkg::NUM_W];
  assign entry_c = (state_ff == intc_pkg::ST_FETCH_VEC) && i_fetch_ack;

  // =========================================================
  // pending
  always_comb begin
    logic [2:0] raise;
    logic hard;
    raise = {i_fault_req[2] | thumb_err_ff,
      i_fault_req[1] | i_bus_err, i_fault_req[0]};
    hard = 1'b0;
    set_c = '0;
    set_c[intc_pkg::IRQ_BASE +: intc_pkg::N_IRQ] = vec_req_c;
    set_c[intc_pkg::EXC_NMI] = nmi_lvl_c & ~nmi_lvl_ff;
    for (int f = 0; f < intc_pkg::N_FAULT; f++) begin
      if (i_fault_en[f] && !i_primask &&
          kpre_c[intc_pkg::EXC_MEM + f] < run_key_c) begin
        set_c[intc_pkg::EXC_MEM + f] = raise[f];
      end else begin
        hard = hard | raise[f];
      end
    end
    set_c[intc_pkg::EXC_HARD] = hard;
    set_c[intc_pkg::EXC_SVC] = i_svc_req;
    set_c[intc_pkg::EXC_DBG] = i_dbg_req;
    set_c[intc_pkg::EXC_PENDED_SERVICE_REQUEST] = i_pended_service_request_req;
    set_c[intc_pkg::EXC_TICK] = i_tick_req;
    clr_c = '0;
    if (entry_c) begin
      clr_c[target_ff] = 1'b1;
    end
  end

  // a request landing on its own clear stays pending
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= ((pend_ff & ~clr_c) | set_c) & ~intc_pkg::RESV_EXC_MASK;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      active_ff <= '0;
    end else begin
      if (ret_c) begin
        active_ff[cur_c[5:0]] <= 1'b0;
      end
      if (entry_c) begin
        active_ff[target_ff] <= 1'b1;
      end
    end
  end

  // =========================================================
  // entry and exit sequencing
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= intc_pkg::ST_FETCH_SP;
      fetch_ff <= '{req: 1'b1, addr: intc_pkg::OFS_SP};
      stack_ff <= '0;
      entry_ff <= '0;
      sp_valid_ff <= 1'b0;
      msp_ff <= '0;
      target_ff <= '0;
      chain_ff <= 1'b0;
      thumb_err_ff <= 1'b0;
    end else begin
      entry_ff.valid <= 1'b0;
      sp_valid_ff <= 1'b0;
      thumb_err_ff <= 1'b0;
      case (state_ff)
        intc_pkg::ST_FETCH_SP: begin
          if (i_fetch_ack) begin
            msp_ff <= i_fetch_data;
            sp_valid_ff <= 1'b1;
            fetch_ff.addr <= intc_pkg::OFS_RESET;
            state_ff <= intc_pkg::ST_FETCH_RST;
          end
        end
        intc_pkg::ST_FETCH_RST: begin
          if (i_fetch_ack) begin
            fetch_ff.req <= 1'b0;
            entry_ff <= '{valid: 1'b1, num: intc_pkg::EXC_RESET,
              handler: i_fetch_data & ~intc_pkg::THUMB_BIT,
              tail_chain: 1'b0};
            state_ff <= intc_pkg::ST_RUN;
          end
        end
        intc_pkg::ST_RUN: begin
          if (ret_c && chain_c) begin
            target_ff <= win_c[5:0];
            chain_ff <= 1'b1;
            fetch_ff <= '{req: 1'b1, addr: intc_pkg::vec_addr_t'(
              {win_c[5:0], intc_pkg::VEC_PAD})};
            state_ff <= intc_pkg::ST_FETCH_VEC;
          end else if (ret_c) begin
            stack_ff.pop <= 1'b1;
            state_ff <= intc_pkg::ST_UNSTACK;
          end else if (take_c) begin
            target_ff <= win_c[5:0];
            chain_ff <= 1'b0;
            stack_ff.push <= 1'b1;
            state_ff <= intc_pkg::ST_STACK;
          end
        end
        intc_pkg::ST_STACK: begin
          target_ff <= tgt_c;
          if (i_stack_done) begin
            stack_ff.push <= 1'b0;
            fetch_ff <= '{req: 1'b1, addr: intc_pkg::vec_addr_t'(
              {tgt_c, intc_pkg::VEC_PAD})};
            state_ff <= intc_pkg::ST_FETCH_VEC;
          end
        end
        intc_pkg::ST_FETCH_VEC: begin
          if (i_fetch_ack) begin
            fetch_ff.req <= 1'b0;
            entry_ff <= '{valid: 1'b1, num: target_ff,
              handler: i_fetch_data & ~intc_pkg::THUMB_BIT,
              tail_chain: chain_ff};
            thumb_err_ff <= ~i_fetch_data[0];
            state_ff <= intc_pkg::ST_RUN;
          end
        end
        intc_pkg::ST_UNSTACK: begin
          if (i_stack_done) begin
            stack_ff.pop <= 1'b0;
            state_ff <= intc_pkg::ST_RUN;
          end
        end
        default: state_ff <= intc_pkg::ST_RUN;
      endcase
    end
  end

  assign o_fetch = fetch_ff;
  assign o_stack = stack_ff;
  assign o_entry = entry_ff;
  assign o_sp_valid = sp_valid_ff;
  assign o_main_stack_pointer = msp_ff;

endmodule // vectored_interrupt_routing

// [vectored_interrupt_routing_test.sv]
// self-checking bench for the vectored interrupt routing block
// assumes intc_pkg, core_model and the checker are compiled first
`timescale 1ns/100ps
module vectored_interrupt_routing_test;
  typedef struct packed {
    logic [4:0] vec;
    logic [1:0] sel;
    logic [1:0] src;
    logic seen;
  } row_t;
  localparam logic [31:0] SP_WORD = 32'h2000_0ff0;
  row_t rows [8] = '{'{5'h00, 2'h0, 2'h0, 1'b1}, '{5'h01, 2'h1, 2'h1, 1'b1},
    '{5'h04, 2'h2, 2'h2, 1'b1}, '{5'h14, 2'h1, 2'h1, 1'b1},
    '{5'h1f, 2'h3, 2'h0, 1'b1}, '{5'h03, 2'h0, 2'h1, 1'b0},
    '{5'h02, 2'h0, 2'h0, 1'b0}, '{5'h11, 2'h2, 2'h0, 1'b0}};
  int sys_num [7] = '{4, 5, 6, 11, 12, 14, 15};
  logic i_mclk, i_rst_b, i_primask, i_bus_err, i_svc_req, i_dbg_req;
  logic i_pended_service_request_req, i_tick_req, i_nmi_en, i_fetch_ack, i_stack_done;
  logic i_exc_return;
  logic [31:0] i_fixed_src, i_array_line, i_irq_en, i_fetch_data;
  logic [15:0] i_dma_terminal_out_low, i_dma_terminal_out_high;
  logic [31:0][1:0] i_src_sel;
  logic [31:0][7:0] i_irq_prio;
  logic [6:0][7:0] i_sys_prio;
  logic [2:0] i_fault_en, i_prio_group, i_fault_req, i_nmi_pin;
  logic [3:0] i_prio_bits, wait_cyc;
  logic [7:0] i_pins, sys_req;
  intc_pkg::fetch_t o_fetch;
  intc_pkg::stack_t o_stack;
  intc_pkg::entry_t o_entry;
  logic o_sp_valid;
  logic [31:0] o_main_stack_pointer;
  int n_fail = 0;
  int total_checks = 0;

  assign i_fault_req = {sys_req[2], sys_req[7], sys_req[0]};
  assign {i_tick_req, i_pended_service_request_req, i_dbg_req, i_svc_req} = sys_req[6:3];
  assign i_bus_err = sys_req[1];

  vectored_interrupt_routing dut (.i_mclk, .i_rst_b, .i_fixed_src,
    .i_dma_terminal_out_low, .i_dma_terminal_out_high, .i_array_line,
    .i_src_sel, .i_irq_en, .i_irq_prio, .i_sys_prio, .i_fault_en,
    .i_prio_bits, .i_prio_group, .i_primask, .i_fault_req, .i_bus_err,
    .i_svc_req, .i_dbg_req, .i_pended_service_request_req, .i_tick_req, .i_pins,
    .i_nmi_en, .i_nmi_pin, .i_fetch_ack, .i_fetch_data, .i_stack_done,
    .i_exc_return, .o_fetch, .o_stack, .o_entry, .o_sp_valid,
    .o_main_stack_pointer);
  core_model #(.SP_WORD(SP_WORD)) core (.i_mclk, .i_rst_b,
    .i_fetch(o_fetch), .i_stack(o_stack), .i_wait(wait_cyc),
    .o_ack(i_fetch_ack), .o_data(i_fetch_data), .o_done(i_stack_done));

  // =====================================================
  // helpers
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic pulse(input int vec, input int src,
                       input logic [31:0] extra = 32'h0);
    @(posedge i_mclk);
    case (src)
      0: i_fixed_src <= (32'h1 << vec) | extra;
      1: if (vec < 16) i_dma_terminal_out_low[vec] <= 1'b1;
         else i_dma_terminal_out_high[vec - 16] <= 1'b1;
      2: i_array_line[vec] <= 1'b1;
      3: sys_req <= 8'h01 << vec;
      default: i_pins[vec] <= 1'b1;
    endcase
    // pins pass a filter that drops one-cycle pulses
    if (src > 3) @(posedge i_mclk);
    @(posedge i_mclk);
    i_fixed_src <= 32'h0;
    i_array_line <= 32'h0;
    i_dma_terminal_out_low <= 16'h0;
    i_dma_terminal_out_high <= 16'h0;
    sys_req <= 8'h0;
    i_pins <= 8'h0;
  endtask

  task automatic expect_entry(input logic seen, input int num,
                              input logic tail);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 40 && !hit; i++) begin
      @(posedge i_mclk);
      #1;
      hit = (o_entry.valid === 1'b1);
    end
    check("entry seen", seen, hit);
    if (hit) begin
      check("entry number", num, o_entry.num);
      check("tail chain", tail, o_entry.tail_chain);
      check("handler", {20'h0, num[5:0], 6'h0}, o_entry.handler);
    end
  endtask

  task automatic ret();
    @(posedge i_mclk) i_exc_return <= 1'b1;
    @(posedge i_mclk) i_exc_return <= 1'b0;
    // a return counts only in run, so let any pop finish first
    @(posedge i_mclk);
    #1;
    while (o_stack.pop === 1'b1) begin
      @(posedge i_mclk);
      #1;
    end
  endtask

  task automatic boot();
    @(posedge i_mclk) i_rst_b <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    check("fetch in reset", 32'h400, o_fetch);
    check("idle in reset", 32'h0, {o_entry.valid, o_sp_valid, o_stack});
    @(posedge i_mclk) i_rst_b <= 1'b1;
    for (int i = 0; i < 20 && o_sp_valid !== 1'b1; i++) begin
      @(posedge i_mclk);
      #1;
    end
    check("stack pointer", SP_WORD, o_main_stack_pointer);
    expect_entry(1'b1, 1, 1'b0);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  // hang guard, well beyond the under two thousand cycles the tests take
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_fail++;
    complete_run();
  end

  // =====================================================
  // tests
  initial begin
    i_rst_b = 1'b0;
    i_primask = 1'b0;
    i_nmi_en = 1'b0;
    i_exc_return = 1'b0;
    i_fixed_src = 32'h0;
    i_array_line = 32'h0;
    i_irq_en = 32'hffff_ffff;
    i_dma_terminal_out_low = 16'h0;
    i_dma_terminal_out_high = 16'h0;
    i_src_sel = 64'h0;
    i_irq_prio = {32{8'h80}};
    i_sys_prio = 56'h0;
    i_fault_en = 3'h7;
    i_prio_group = 3'h0;
    i_nmi_pin = 3'h0;
    i_prio_bits = 4'h8;
    wait_cyc = 4'h0;
    i_pins = 8'h0;
    sys_req = 8'h0;
    boot();
    foreach (rows[r]) begin
      @(posedge i_mclk) i_src_sel[rows[r].vec] <= rows[r].sel;
      pulse(rows[r].vec, rows[r].src);
      expect_entry(rows[r].seen, rows[r].vec + 16, 1'b0);
      if (rows[r].seen) ret();
      @(posedge i_mclk) i_src_sel <= 64'h0;
    end
    $display("test source rows done");
    pulse(9, 0, 32'h0000_0020);
    expect_entry(1'b1, 21, 1'b0);
    ret();
    expect_entry(1'b1, 25, 1'b1);
    ret();
    $display("test equal priority done");
    // same two priorities: preempt with no grouping, wait with all-sub
    for (int g = 0; g < 8; g += 7) begin
      @(posedge i_mclk) i_prio_group <= g[2:0];
      i_irq_prio[9] <= 8'h40;
      pulse(5, 0);
      expect_entry(1'b1, 21, 1'b0);
      pulse(9, 0);
      expect_entry(g == 0, 25, 1'b0);
      ret();
      if (g != 0) expect_entry(1'b1, 25, 1'b1);
      ret();
    end
    @(posedge i_mclk) i_prio_group <= 3'h0;
    $display("test grouping done");
    // one bit asked, three kept: 0x80 and 0x90 tie, lower vector wins
    @(posedge i_mclk) i_prio_bits <= 4'h1;
    i_irq_prio[4] <= 8'h90;
    pulse(4, 0, 32'h0000_0020);
    expect_entry(1'b1, 20, 1'b0);
    ret();
    expect_entry(1'b1, 21, 1'b1);
    ret();
    @(posedge i_mclk) i_prio_bits <= 4'h8;
    $display("test priority bits done");
    @(posedge i_mclk) wait_cyc <= 4'h6;
    i_irq_prio[11] <= 8'h40;
    pulse(10, 0);
    for (int i = 0; i < 20 && o_stack.push !== 1'b1; i++) begin
      @(posedge i_mclk);
      #1;
    end
    pulse(11, 0);
    expect_entry(1'b1, 27, 1'b0);
    ret();
    expect_entry(1'b1, 26, 1'b1);
    ret();
    @(posedge i_mclk) wait_cyc <= 4'h0;
    $display("test late arrival done");
    for (int k = 0; k < 7; k++) begin
      pulse(k, 3);
      expect_entry(1'b1, sys_num[k], 1'b0);
      ret();
    end
    @(posedge i_mclk) i_fault_en <= 3'h0;
    pulse(7, 3);
    expect_entry(1'b1, 3, 1'b0);
    ret();
    @(posedge i_mclk) i_fault_en <= 3'h7;
    $display("test system slots done");
    @(posedge i_mclk) i_nmi_en <= 1'b1;
    for (int p = 0; p < 8; p++) begin
      @(posedge i_mclk) i_nmi_pin <= p[2:0];
      pulse(p, 4);
      expect_entry(1'b1, 2, 1'b0);
      ret();
    end
    @(posedge i_mclk) i_nmi_en <= 1'b0;
    pulse(7, 4);
    expect_entry(1'b0, 2, 1'b0);
    $display("test nmi routing done");
    boot();
    $display("test second reset done");
    complete_run();
  end
endmodule // vectored_interrupt_routing_test
